// File: pdm_silence_pattern_control.sv
// pdm input front end: channel pick, silence pattern control, mode
//
// Summary of operation
// - select pin low left, high right
// - candidate byte repeats, four ones four zeros
// - patterns match in any bit rotation
// - float outputs from byte 32 of run
// - apply setting at byte 129 of run
// - configuration patterns only during power-up
// - after power-up only mute and power-down
// - configuration allowed again after pattern power-down
// - clock restart is a fresh power-up
// - run beyond 128 keeps outputs floating
// - defaults pattern or supply loss resets settings
// - clip limiting off, on by pattern
// - gain 0 dB, pattern selects -3/+3 dB
// - normal edge rate, pattern selects slow
// - pattern disables power-stage section scaling
// - pattern enables bandwidth extension
// - test pattern changes no user setting
// - turn-on within 2 ms, off within 5 us
// - mute after 32 mute bytes, leave immediately
// - power-down after 128 bytes, leave on change
// - no clock means power-down
`timescale 1ns/10ps
`include "pdm_silence_consts.svh"
module pdm_silence_pattern_control #(
    parameter int TON_CYCLES  = `TON_CYCLES,
    parameter int WDOG_CYCLES = `WDOG_CYCLES
) (
    input  wire logic                    i_core_clk,
    input  wire logic                    i_sys_rst,
    input  wire logic                    i_pdm_clk,
    input  wire logic                    i_pdm_data,
    input  wire logic                    i_channel_select,
    output logic                         o_audio_bit,
    output logic                         o_out_float,
    output logic                         o_mute,
    output logic                         o_power_down,
    output logic                         o_operating,
    output logic                         o_powerup_phase,
    output pdm_silence_pkg::settings_t   o_settings
);
    import pdm_silence_pkg::*;

    localparam int TW = $clog2(TON_CYCLES + 1);
    localparam int WW = $clog2(WDOG_CYCLES + 1);

    if (TON_CYCLES < 1 || TON_CYCLES > `TON_CYCLES) begin : g_bad_ton
        $error("turn-on count out of range");
    end
    if (WDOG_CYCLES < 4 || WDOG_CYCLES > `TOFF_CYCLES) begin : g_bad_wdog
        $error("clock watchdog count out of range");
    end

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic is_cfg(input pat_t p);
        return (p != PAT_NONE) && (p != PAT_MUTE) && (p != PAT_PDOWN);
    endfunction

    function automatic logic accepted(input pat_t p, input logic cfg_ok);
        return (p == PAT_MUTE) || (p == PAT_PDOWN) || (is_cfg(p) && cfg_ok);
    endfunction

    function automatic settings_t default_settings();
        settings_t s;
        s.clip_on     = `DEF_CLIP_ON;
        s.gain        = GAIN_0DB;
        s.slope_low   = `DEF_SLOPE_LOW;
        s.scaling_off = `DEF_SCALING_OFF;
        s.bw_ext      = `DEF_BW_EXT;
        return s;
    endfunction

    // core side state read by the link
    logic          rst_q;
    logic          cfg_ok;
    logic          link_hold;
    // link side
    logic          rst_l;
    logic          hold_l;
    logic          cfg_ok_l;
    logic          sel_l;
    logic          link_rst;
    logic          right_bit;
    logic          hb;
    logic [7:0]    shift;
    logic [2:0]    bit_cnt;
    logic          next_bit;
    logic          byte_done;
    logic [7:0]    cur_byte;
    pat_t          cur_pat;
    logic [7:0]    prev_byte;
    logic [7:0]    run_cnt;
    logic [7:0]    next_run;
    logic          cur_acc;
    link_status_t  status;
    pat_t          apply_code;
    logic          apply_tog;

    // --------------------------------------------------------------
    // link clock domain
    // --------------------------------------------------------------
    bit_sync #(.W(4)) u_sync_link (
        .i_clk (i_pdm_clk),
        .i_d   ({rst_q, link_hold, cfg_ok, i_channel_select}),
        .o_q   ({rst_l, hold_l, cfg_ok_l, sel_l})
    );

    assign link_rst = rst_l | hold_l;

    // liveness toggle, kept running while held so the core sees the clock
    always_ff @(posedge i_pdm_clk) begin
        if (rst_l) begin
            hb <= 1'b0;
        end else begin
            hb <= ~hb;
        end
    end

    // right half arrives on the falling edge
    always_ff @(negedge i_pdm_clk) begin
        if (link_rst) begin
            right_bit <= 1'b0;
        end else begin
            right_bit <= i_pdm_data;
        end
    end

    assign next_bit  = sel_l ? right_bit : i_pdm_data;
    assign byte_done = (bit_cnt == 3'h7);
    assign cur_byte  = {shift[6:0], next_bit};

    always_ff @(posedge i_pdm_clk) begin
        if (link_rst) begin
            shift       <= 8'h00;
            bit_cnt     <= 3'h0;
            o_audio_bit <= 1'b0;
        end else begin
            shift       <= cur_byte;
            bit_cnt     <= bit_cnt + 3'h1;
            o_audio_bit <= next_bit;
        end
    end

    silence_classify u_classify (
        .i_byte (cur_byte),
        .o_pat  (cur_pat)
    );

    always_comb begin
        next_run = 8'h00;
        if (cur_pat != PAT_NONE) begin
            if (cur_byte != prev_byte) begin
                next_run = 8'h01;
            end else if (run_cnt == `RUN_MAX) begin
                next_run = run_cnt;
            end else begin
                next_run = run_cnt + 8'h01;
            end
        end
    end

    assign cur_acc = accepted(cur_pat, cfg_ok_l);

    always_ff @(posedge i_pdm_clk) begin
        if (link_rst) begin
            prev_byte <= 8'h00;
            run_cnt   <= 8'h00;
            status    <= '0;
        end else if (byte_done) begin
            prev_byte        <= cur_byte;
            run_cnt          <= next_run;
            status.float_req <= cur_acc && (next_run >= `RUN_FLOAT);
            status.mute      <= (cur_pat == PAT_MUTE) && (next_run >= `RUN_FLOAT);
            status.pdown     <= (cur_pat == PAT_PDOWN) && (next_run >= `RUN_APPLY);
        end
    end

    // setting event; the code holds for at least 128 bytes afterwards
    always_ff @(posedge i_pdm_clk) begin
        if (link_rst) begin
            apply_code <= PAT_NONE;
            apply_tog  <= 1'b0;
        end else if (byte_done && cur_acc && is_cfg(cur_pat)
                     && run_cnt == `RUN_APPLY && next_run == `RUN_MAX) begin
            apply_code <= cur_pat;
            apply_tog  <= ~apply_tog;
        end
    end

    // --------------------------------------------------------------
    // core clock domain
    // --------------------------------------------------------------
    logic          hb_s;
    logic          hb_d;
    logic          tog_s;
    logic          tog_d;
    link_status_t  status_s;
    logic          hb_edge;
    logic          apply_edge;
    logic [WW-1:0] wdog;
    logic          clk_absent;
    logic [TW-1:0] ton_cnt;
    logic          ton_done;
    mode_t         mode;
    mode_t         next_mode;
    settings_t     settings;

    bit_sync #(.W(5)) u_sync_core (
        .i_clk (i_core_clk),
        .i_d   ({hb, apply_tog, status}),
        .o_q   ({hb_s, tog_s, status_s})
    );

    always_ff @(posedge i_core_clk) begin
        rst_q <= i_sys_rst;
        hb_d  <= hb_s;
        tog_d <= tog_s;
    end

    assign hb_edge    = hb_s ^ hb_d;
    assign apply_edge = tog_s ^ tog_d;
    assign clk_absent = (wdog == WW'(WDOG_CYCLES));
    assign ton_done   = (ton_cnt == TW'(TON_CYCLES - 1));

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || hb_edge) begin
            wdog <= '0;
        end else if (!clk_absent) begin
            wdog <= wdog + WW'(1);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || mode != MD_BOOT) begin
            ton_cnt <= '0;
        end else if (!ton_done) begin
            ton_cnt <= ton_cnt + TW'(1);
        end
    end

    always_comb begin
        next_mode = mode;
        case (mode)
            MD_OFF: begin
                if (hb_edge) next_mode = MD_BOOT;
            end
            MD_BOOT: begin
                if (clk_absent) next_mode = MD_OFF;
                else if (status_s.pdown) next_mode = MD_PD;
                else if (ton_done) next_mode = MD_RUN;
            end
            MD_RUN: begin
                if (clk_absent) next_mode = MD_OFF;
                else if (status_s.pdown) next_mode = MD_PD;
            end
            MD_PD: begin
                if (clk_absent) next_mode = MD_OFF;
                else if (!status_s.pdown) next_mode = MD_BOOT;
            end
            default: next_mode = MD_OFF;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            mode      <= MD_OFF;
            cfg_ok    <= 1'b1;
            link_hold <= 1'b1;
        end else begin
            mode      <= next_mode;
            cfg_ok    <= (next_mode == MD_BOOT) || (next_mode == MD_PD);
            link_hold <= (next_mode == MD_OFF);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            settings <= default_settings();
        end else if (apply_edge) begin
            case (apply_code)
                PAT_CLIP:     settings.clip_on     <= 1'b1;
                PAT_GAIN_DN:  settings.gain        <= GAIN_M3;
                PAT_GAIN_UP:  settings.gain        <= GAIN_P3;
                PAT_SLOPE:    settings.slope_low   <= 1'b1;
                PAT_SCALE:    settings.scaling_off <= 1'b1;
                PAT_BWE:      settings.bw_ext      <= 1'b1;
                PAT_DEFAULTS: settings             <= default_settings();
                default:      settings             <= settings;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_out_float     <= 1'b1;
            o_mute          <= 1'b0;
            o_power_down    <= 1'b1;
            o_operating     <= 1'b0;
            o_powerup_phase <= 1'b1;
        end else begin
            o_out_float     <= (mode != MD_RUN) || status_s.float_req || status_s.mute;
            o_mute          <= status_s.mute;
            o_power_down    <= (mode == MD_OFF) || (mode == MD_PD);
            o_operating     <= (mode == MD_RUN) && !status_s.float_req && !status_s.mute;
            o_powerup_phase <= cfg_ok;
        end
    end

    assign o_settings = settings;

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    sequence s_boot_last;
        mode == MD_BOOT && ton_done && !status_s.pdown && !clk_absent;
    endsequence

    boot_expiry_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        s_boot_last |=> mode == MD_RUN ##1 !o_powerup_phase)
        else $error("turn-on delay expiry did not reach run");

    clk_loss_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        mode == MD_RUN && clk_absent |=> mode == MD_OFF ##1 o_power_down)
        else $error("missing clock did not power down");

    restart_boot_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        mode == MD_OFF && hb_edge |=> mode == MD_BOOT && cfg_ok)
        else $error("clock restart did not start power-up");

    pd_entry_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        mode == MD_RUN && status_s.pdown && !clk_absent |=> mode == MD_PD && cfg_ok)
        else $error("power-down pattern not obeyed");

    defaults_apply_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        apply_edge && apply_code == PAT_DEFAULTS |=> settings == default_settings())
        else $error("defaults pattern did not reset settings");

    test_keep_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        apply_edge && apply_code == PAT_TEST |=> $stable(settings))
        else $error("test pattern changed a setting");

    run_clear_a: assert property (@(posedge i_pdm_clk) disable iff (link_rst)
        byte_done && (cur_byte != prev_byte || cur_pat == PAT_NONE) |=> run_cnt <= 8'h01)
        else $error("run counter not cleared");

    float_start_a: assert property (@(posedge i_pdm_clk) disable iff (link_rst)
        byte_done && cur_acc && next_run == `RUN_FLOAT |=> status.float_req)
        else $error("outputs not floated at byte 32");

    apply_moment_a: assert property (@(posedge i_pdm_clk) disable iff (link_rst)
        $changed(apply_tog) |-> $past(run_cnt) == `RUN_APPLY && run_cnt == `RUN_MAX)
        else $error("setting applied at the wrong byte");

    late_ignore_a: assert property (@(posedge i_pdm_clk) disable iff (link_rst)
        byte_done && !cfg_ok_l && is_cfg(cur_pat) |=> !status.float_req && !$changed(apply_tog))
        else $error("configuration pattern honoured after power-up");

endmodule

// File: pdm_silence_consts.svh
// constants for the pdm silence pattern control block
`ifndef PDM_SILENCE_CONSTS_SVH
`define PDM_SILENCE_CONSTS_SVH

// --------------------------------------------------------------
// base silence bytes
// --------------------------------------------------------------
`define PAT_BYTE_TEST     8'hd1
`define PAT_BYTE_CLIP     8'hd2
`define PAT_BYTE_GAIN_DN  8'hd4
`define PAT_BYTE_GAIN_UP  8'hd8
`define PAT_BYTE_SLOPE    8'he1
`define PAT_BYTE_SCALE    8'he2
`define PAT_BYTE_BWE      8'he4
`define PAT_BYTE_DEFAULTS 8'haa
`define PAT_BYTE_MUTE     8'h66
`define PAT_BYTE_PDOWN    8'hac
`define PAT_ONES          4'h4

// --------------------------------------------------------------
// run lengths in bytes
// --------------------------------------------------------------
`define RUN_FLOAT         8'h20
`define RUN_APPLY         8'h80
`define RUN_MAX           8'h81

// --------------------------------------------------------------
// reset values of stored settings
// --------------------------------------------------------------
`define DEF_CLIP_ON       1'b0
`define DEF_SLOPE_LOW     1'b0
`define DEF_SCALING_OFF   1'b0
`define DEF_BW_EXT        1'b0

// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define CORE_CLK_NS       40
`define TON_NS            2000000
`define TOFF_NS           5000
`define TON_CYCLES        (`TON_NS / `CORE_CLK_NS)
`define TOFF_CYCLES       (`TOFF_NS / `CORE_CLK_NS)
`define WDOG_CYCLES       8

`endif

// File: pdm_silence_pkg.sv
// types of the pdm silence pattern control block
package pdm_silence_pkg;

    // ----------------------------------------------------------
    // recognised patterns
    // ----------------------------------------------------------
    typedef enum logic [3:0] {
        PAT_NONE     = 4'h0,
        PAT_TEST     = 4'h1,
        PAT_CLIP     = 4'h2,
        PAT_GAIN_DN  = 4'h3,
        PAT_GAIN_UP  = 4'h4,
        PAT_SLOPE    = 4'h5,
        PAT_SCALE    = 4'h6,
        PAT_BWE      = 4'h7,
        PAT_DEFAULTS = 4'h8,
        PAT_MUTE     = 4'h9,
        PAT_PDOWN    = 4'ha
    } pat_t;

    typedef enum logic [1:0] {
        GAIN_0DB = 2'h0,
        GAIN_M3  = 2'h1,
        GAIN_P3  = 2'h2
    } gain_t;

    typedef struct packed {
        logic  clip_on;
        gain_t gain;
        logic  slope_low;
        logic  scaling_off;
        logic  bw_ext;
    } settings_t;

    typedef struct packed {
        logic float_req;
        logic mute;
        logic pdown;
    } link_status_t;

    typedef enum logic [3:0] {
        MD_OFF  = 4'b0001,
        MD_BOOT = 4'b0010,
        MD_RUN  = 4'b0100,
        MD_PD   = 4'b1000
    } mode_t;

endpackage

// File: bit_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
module bit_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta;

    if (W < 1) begin : g_bad_w
        $error("bit_sync width must be at least one");
    end

    always_ff @(posedge i_clk) begin
        meta <= i_d;
        o_q  <= meta;
    end
endmodule

// File: silence_classify.sv
// maps a received byte to a silence pattern, any bit phase
`timescale 1ns/10ps
`include "pdm_silence_consts.svh"
module silence_classify (
    input  wire logic [7:0]        i_byte,
    output pdm_silence_pkg::pat_t  o_pat
);
    import pdm_silence_pkg::*;

    function automatic logic rot_hit(input logic [7:0] b, input logic [7:0] base);
        logic hit;
        hit = 1'b0;
        for (int r = 0; r < 8; r++) begin
            if (((base << r) | (base >> (8 - r))) == b) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    always_comb begin
        o_pat = PAT_NONE;
        if ($countones(i_byte) == int'(`PAT_ONES)) begin
            if (rot_hit(i_byte, `PAT_BYTE_TEST)) o_pat = PAT_TEST;
            else if (rot_hit(i_byte, `PAT_BYTE_CLIP)) o_pat = PAT_CLIP;
            else if (rot_hit(i_byte, `PAT_BYTE_GAIN_DN)) o_pat = PAT_GAIN_DN;
            else if (rot_hit(i_byte, `PAT_BYTE_GAIN_UP)) o_pat = PAT_GAIN_UP;
            else if (rot_hit(i_byte, `PAT_BYTE_SLOPE)) o_pat = PAT_SLOPE;
            else if (rot_hit(i_byte, `PAT_BYTE_SCALE)) o_pat = PAT_SCALE;
            else if (rot_hit(i_byte, `PAT_BYTE_BWE)) o_pat = PAT_BWE;
            else if (rot_hit(i_byte, `PAT_BYTE_DEFAULTS)) o_pat = PAT_DEFAULTS;
            else if (rot_hit(i_byte, `PAT_BYTE_MUTE)) o_pat = PAT_MUTE;
            else if (rot_hit(i_byte, `PAT_BYTE_PDOWN)) o_pat = PAT_PDOWN;
        end
    end
endmodule

// File: pdm_source.sv
// pdm audio source model with a stoppable bit clock
`timescale 1ns/10ps
module pdm_source (
    input  wire logic i_clk_en,
    output logic      o_pdm_clk,
    output logic      o_pdm_data
);
    logic [7:0] q[$];
    logic [7:0] cur;

    task automatic send(input logic [7:0] b, input int n);
        repeat (n) q.push_back(b);
    endtask

    // ------------------------------------------------------
    // bit stream: left bit before rise, right bit before fall
    // ------------------------------------------------------
    initial begin
        o_pdm_clk  = 1'b0;
        o_pdm_data = 1'b0;
        forever begin
            while (!i_clk_en) begin
                o_pdm_data = ~o_pdm_data; // no clock: line wanders
                #3;
            end
            cur = (q.size() != 0) ? q.pop_front() : 8'h00;
            for (int k = 7; k >= 0; k--) begin // msb first
                o_pdm_data = cur[k];
                #1.5 o_pdm_clk = 1'b1;
                #1.5 o_pdm_data = ~cur[k]; // right half is the inverse
                #1.5 o_pdm_clk = 1'b0;
                #1.5;
            end
        end
    end
endmodule

// File: testbench.sv
// self-checking testbench of the pdm silence pattern control block
`timescale 1ns/10ps
module testbench;
    import pdm_silence_pkg::*;
    localparam int TON = 3000;
    logic      i_core_clk;
    logic      i_sys_rst;
    logic      i_channel_select;
    logic      clk_en;
    logic      pdm_clk;
    logic      pdm_data;
    logic      o_audio_bit;
    logic      o_out_float;
    logic      o_mute;
    logic      o_power_down;
    logic      o_operating;
    logic      o_powerup_phase;
    settings_t o_settings;
    settings_t exp_set;
    logic      boot;
    logic      lvl;
    int        error_cnt;
    int        n_checks;
    logic [7:0] cfg_tab[7] = '{8'hd2, 8'hd4, 8'he1, 8'he2, 8'he4, 8'hd1, 8'hd8};

    pdm_source u_src (
        .i_clk_en   (clk_en),
        .o_pdm_clk  (pdm_clk),
        .o_pdm_data (pdm_data)
    );

    pdm_silence_pattern_control #(.TON_CYCLES(TON), .WDOG_CYCLES(8)) dut (
        .i_core_clk       (i_core_clk),
        .i_sys_rst        (i_sys_rst),
        .i_pdm_clk        (pdm_clk),
        .i_pdm_data       (pdm_data),
        .i_channel_select (i_channel_select),
        .o_audio_bit      (o_audio_bit),
        .o_out_float      (o_out_float),
        .o_mute           (o_mute),
        .o_power_down     (o_power_down),
        .o_operating      (o_operating),
        .o_powerup_phase  (o_powerup_phase),
        .o_settings       (o_settings)
    );

    initial begin
        i_core_clk = 1'b0;
        forever #20 i_core_clk = ~i_core_clk;
    end

    // ------------------------------------------------------
    // helpers
    // ------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error: %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask

    // sends n copies of b in a random bit phase, returns when left remain
    task automatic play(input logic [7:0] b, input int n, input int left);
        int r;
        int t;
        r = $urandom % 8;
        t = 0;
        u_src.send(8'((b << r) | (b >> (8 - r))), n);
        while (u_src.q.size() > left && t < 20000) begin
            cyc(1);
            t++;
        end
        if (t >= 20000) check("queue drain", 8'h01, 8'h00);
        cyc(10);
    endtask

    // bench model of the stored settings
    function automatic settings_t upd(input settings_t s, input logic [7:0] b);
        case (b)
            8'hd2: s.clip_on = 1'b1;
            8'hd4: s.gain = GAIN_M3;
            8'hd8: s.gain = GAIN_P3;
            8'he1: s.slope_low = 1'b1;
            8'he2: s.scaling_off = 1'b1;
            8'he4: s.bw_ext = 1'b1;
            8'haa: s = '0;
            default: ;
        endcase
        return s;
    endfunction

    // a stream seen as 129 or more bytes is sent as 130, never-applied as 128
    task automatic cfg(input logic [7:0] b, input int n);
        play(b, n, 0);
        if (boot && n >= 130) exp_set = upd(exp_set, b);
        play(8'h00, 0, 0);
        check("settings", {2'b00, o_settings}, {2'b00, exp_set});
    endtask

    task automatic wait_run;
        int t;
        t = 0;
        while (o_operating !== 1'b1 && t < TON + 2000) begin
            cyc(1);
            t++;
        end
        boot = 1'b0;
        check("operating", {7'h0, o_operating}, 8'h01);
        check("powerup phase", {7'h0, o_powerup_phase}, 8'h00);
        check("float in run", {7'h0, o_out_float}, 8'h00);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge i_core_clk);
        error_cnt++;
        $display("Error: watchdog expected finish seen hang");
        print_verdict();
    end

    // ------------------------------------------------------
    // tests
    // ------------------------------------------------------
    initial begin
        void'($urandom(30));
        i_sys_rst = 1'b1;
        i_channel_select = 1'b0;
        clk_en = 1'b1;
        error_cnt = 0;
        n_checks = 0;
        exp_set = '0;
        boot = 1'b1;
        cyc(6);
        check("reset settings", {2'b00, o_settings}, 8'h00);
        check("reset pdown", {7'h0, o_power_down}, 8'h01);
        i_sys_rst = 1'b0;
        cyc(10);
        check("boot phase", {7'h0, o_powerup_phase}, 8'h01);
        cfg(8'hd8, 128);
        foreach (cfg_tab[i]) cfg(cfg_tab[i], 130);
        cfg(8'haa, 130);
        cfg(8'hd2, 130);
        wait_run();
        $display("test boot configuration done");
        play(8'he1, 150, 15);
        check("float ignored cfg", {7'h0, o_out_float}, 8'h00);
        cfg(8'he1, 150);
        play(8'h66, 31, 0);
        check("mute short run", {7'h0, o_mute}, 8'h00);
        play(8'h66, 60, 20);
        check("mute", {7'h0, o_mute}, 8'h01);
        check("float on mute", {7'h0, o_out_float}, 8'h01);
        check("mute stops amp", {7'h0, o_operating}, 8'h00);
        play(8'h00, 0, 0);
        check("unmute", {7'h0, o_mute}, 8'h00);
        $display("test mute done");
        play(8'hac, 127, 0);
        check("pdown short run", {7'h0, o_power_down}, 8'h00);
        play(8'hac, 160, 20);
        check("pdown", {7'h0, o_power_down}, 8'h01);
        check("pdown phase", {7'h0, o_powerup_phase}, 8'h01);
        play(8'h00, 0, 0);
        check("pdown left", {7'h0, o_power_down}, 8'h00);
        boot = 1'b1;
        cfg(8'he4, 130);
        wait_run();
        $display("test power-down pattern done");
        for (int i = 0; i < 4; i++) begin
            i_channel_select = i[0];
            lvl = 1'($urandom % 2);
            play(lvl ? 8'hff : 8'h00, 20, 15);
            check("audio bit", {7'h0, o_audio_bit}, {7'h0, lvl ^ i[0]});
        end
        i_channel_select = 1'b0;
        $display("test channel select done");
        clk_en = 1'b0;
        cyc(20);
        check("no clock pdown", {7'h0, o_power_down}, 8'h01);
        check("no clock float", {7'h0, o_out_float}, 8'h01);
        clk_en = 1'b1;
        cyc(20);
        check("restart phase", {7'h0, o_powerup_phase}, 8'h01);
        boot = 1'b1;
        cfg(8'hd4, 130);
        $display("test clock restart done");
        clk_en = 1'b0;
        cyc(20);
        check("pdown before supply", {7'h0, o_power_down}, 8'h01);
        i_sys_rst = 1'b1;
        cyc(6);
        exp_set = '0;
        check("supply loss", {2'b00, o_settings}, {2'b00, exp_set});
        $display("test supply loss done");
        print_verdict();
    end
endmodule
